// file: pin_mux_consts.svh
// Register indices, reset values, bit positions and idle levels for the
// multifunction GPIO pin multiplexer. Assumes byte address = 4 * index.
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

`define IDX_SELECT_BASE    8'h25
`define IDX_CIR_MODE       8'hF4
`define IDX_CIR_ROUTE      8'hF0
`define IDX_GPIO_OUT_BASE  8'h40
`define IDX_PIN_LEVEL_BASE 8'h48
`define IDX_STATUS         8'h50
`define SELECT_RESET       48'hFF_E0_FF_00_00_00
`define GPIO_OUT_RESET     8'hFF
`define BIT_MIDI_MODE      6
`define BIT_CIR_ON_INFRARED_TRANSMIT    5
`define BIT_STRAP          0
`define STRAP_SETTLE       3'h4
`define IDLE_SERIAL        1'b1
`define IDLE_BUTTON        1'b1
`define IDLE_AXIS          1'b1
`define IDLE_TACH          1'b0
`define IDLE_FLASH_DATA    1'b0

`endif

// file: pin_mux_pkg.sv
// Types shared by the pin multiplexer modules.
// Assumes ports are numbered 0..5 for GPIO ports 1..6.
package pin_mux_pkg;
  typedef logic [7:0] port_bits_type;
  typedef struct packed {
    port_bits_type out;
    port_bits_type oe;
  } pin_drive_type;
endpackage

// file: sync3.sv
// Three-flop input synchroniser with a two-flop agreement filter.
// Assumes the input is asynchronous to clk.
`timescale 1ns/100ps
module sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // First flop feeds only the second one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= d;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts only once flops two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & q);
    end
  end
endmodule

// file: port_mux.sv
// One 8-bit port: each bit goes either to its primary function or to an
// open-drain GPIO bit. Assumes function drive is already resolved.
`timescale 1ns/100ps
module port_mux
  import pin_mux_pkg::*;
(
  input  wire port_bits_type gpio_select,
  input  wire port_bits_type gpio_out,
  input  wire pin_drive_type func_drive,
  output pin_drive_type      pin_drive
);
  // GPIO bits pull low only; the function is cut off from the pin
  always_comb begin
    pin_drive.out = func_drive.out & ~gpio_select;
    pin_drive.oe  = (func_drive.oe & ~gpio_select)
                  | (~gpio_out & gpio_select);
  end
endmodule

// file: gpio_pin_mux.sv
// Multifunction GPIO pin multiplexer with APB configuration registers.
// Assumes APB master on clk; pin levels arrive asynchronously.
//
// Contract
// - Pin 82 is GPIO 6.4 when select 6 bit 4 is set, else IR transmit, or CIR transmit when both CIR mode and route bits are set.
// - Pin 83 is GPIO 6.5 when select bit 5 is set, else it feeds IR receive, and CIR receive too in MIDI mode.
// - Pin 84 is GPIO 6.6 when select bit 6 is set, else CIR transmit, or music serial output in MIDI mode.
// - Pin 85 is GPIO 6.7 when select bit 7 is set, else CIR receive, or music serial input in MIDI mode.
// - Port 1 bits share pins with flash data lines 0 to 7, either flash data or open-drain GPIO.
// - Port 2 bits share pins with flash address lines 0 to 7.
// - Port 3 bits share pins with flash address lines 8 to 15.
// - Port 4 shares pins with joystick axes (bits 0,1,4,5) and buttons (bits 2,3,6,7).
// - Port 5 bits 0-1 are flash address 16-17, bits 2-4 the flash strobes, bits 5-6 tach inputs 1-2.
// - Port 5 bit 7 is GPIO, tach input 3 or flash address 18 by configuration.
// - Port 6 bits 0-2 are open-drain fan controls and bit 3 the power event output.
// - Flash address 18 takes the shared tach pin when the large flash strap is set.
`timescale 1ns/100ps
`include "pin_mux_consts.svh"
module gpio_pin_mux
  import pin_mux_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire port_bits_type [5:0]  pin_in,
  output pin_drive_type [5:0]       pin_drive,
  input  wire logic                 large_flash_strap,
  input  wire logic [18:0]          flash_address_lines,
  input  wire port_bits_type        flash_data_out,
  input  wire logic                 flash_data_oe,
  output port_bits_type             flash_data_lines,
  input  wire logic                 flash_read_strobe_n,
  input  wire logic                 flash_chip_select_n,
  input  wire logic                 flash_write_enable_n,
  input  wire logic [3:0]           joystick_axis_discharge,
  output logic      [3:0]           joystick_axis_level,
  output logic      [3:0]           joystick_button,
  output logic      [2:0]           fan_tach_input,
  input  wire logic [2:0]           fan_control_output,
  input  wire logic                 power_event_output_n,
  input  wire logic                 infrared_transmit,
  output logic                      infrared_receive,
  input  wire logic                 consumer_infrared_transmit,
  output logic                      consumer_infrared_receive,
  input  wire logic                 music_serial_output,
  output logic                      music_serial_input
);
  import pin_mux_pkg::*;

  port_bits_type [5:0] gpio_select;
  port_bits_type [5:0] gpio_out;
  port_bits_type [5:0] pin_level;
  pin_drive_type [5:0] func_drive;
  logic                midi_mode;
  logic                cir_on_infrared_transmit;
  logic                strap_level;
  logic                strap_latched;
  logic                strap_done;
  logic [2:0]          strap_count;
  logic [7:0]          reg_index;
  logic                index_ok;
  logic                access_cycle;
  logic                write_strobe;
  logic [31:0]         next_prdata;
  logic                next_error;
  logic                read_error;
  logic                write_error;
  logic                error_flag;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers for all pins and the strap
  sync3 #(
    .WIDTH(49)
  ) pin_sync (
    .clk(clk),
    .rst(rst),
    .d  ({large_flash_strap, pin_in}),
    .q  ({strap_level, pin_level})
  );

  // Strap is caught once, after the synchroniser has settled
  // strap capture point
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_count   <= '0;
      strap_done    <= 1'b0;
      strap_latched <= 1'b0;
    end else if (!strap_done) begin
      strap_count <= strap_count + 3'h1;
      if (strap_count == `STRAP_SETTLE) begin
        strap_done    <= 1'b1;
        strap_latched <= strap_level;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, so the answer comes in the access cycle
  assign reg_index    = paddr[9:2];
  assign index_ok     = (paddr[ADDR_W-1:10] == '0);
  assign access_cycle = psel & penable;
  assign write_strobe = access_cycle & pwrite & ~error_flag;
  assign pready       = 1'b1;
  assign pslverr      = access_cycle & error_flag;

  // Read mux and error check, looked up during the setup cycle
  always_comb begin
    next_prdata = '0;
    read_error  = 1'b1;
    write_error = 1'b1;
    for (int p = 0; p < 6; p++) begin
      if (reg_index == `IDX_SELECT_BASE + 8'(p)) begin
        next_prdata[7:0] = gpio_select[p];
        read_error       = 1'b0;
        write_error      = 1'b0;
      end
      if (reg_index == `IDX_GPIO_OUT_BASE + 8'(p)) begin
        next_prdata[7:0] = gpio_out[p];
        read_error       = 1'b0;
        write_error      = 1'b0;
      end
      if (reg_index == `IDX_PIN_LEVEL_BASE + 8'(p)) begin
        next_prdata[7:0] = pin_level[p];
        read_error       = 1'b0;
      end
    end
    if (reg_index == `IDX_CIR_MODE) begin
      next_prdata[`BIT_MIDI_MODE] = midi_mode;
      read_error                  = 1'b0;
      write_error                 = 1'b0;
    end
    if (reg_index == `IDX_CIR_ROUTE) begin
      next_prdata[`BIT_CIR_ON_INFRARED_TRANSMIT] = cir_on_infrared_transmit;
      read_error                    = 1'b0;
      write_error                   = 1'b0;
    end
    if (reg_index == `IDX_STATUS) begin
      next_prdata[`BIT_STRAP] = strap_latched;
      read_error              = 1'b0;
    end
    next_error = ~index_ok | (pwrite ? write_error : read_error);
  end

  // Read data and error captured at setup so they come from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata     <= '0;
      error_flag <= 1'b0;
    end else if (psel && !penable) begin
      prdata     <= pwrite ? 32'h0000_0000 : next_prdata;
      error_flag <= next_error;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-port select and GPIO output registers
  for (genvar p = 0; p < 6; p++) begin : g_port_regs
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        gpio_select[p] <= port_bits_type'(`SELECT_RESET >> (8 * p));
      end else if (write_strobe
                   && reg_index == `IDX_SELECT_BASE + 8'(p)) begin
        gpio_select[p] <= pwdata[7:0];
      end
    end

    // Reset releases every open-drain GPIO bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        gpio_out[p] <= `GPIO_OUT_RESET;
      end else if (write_strobe
                   && reg_index == `IDX_GPIO_OUT_BASE + 8'(p)) begin
        gpio_out[p] <= pwdata[7:0];
      end
    end

    port_mux port_cell (
      .gpio_select(gpio_select[p]),
      .gpio_out   (gpio_out[p]),
      .func_drive (func_drive[p]),
      .pin_drive  (pin_drive[p])
    );
  end

  // Consumer infrared mode and transmit routing bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      midi_mode   <= 1'b0;
      cir_on_infrared_transmit <= 1'b0;
    end else if (write_strobe && reg_index == `IDX_CIR_MODE) begin
      midi_mode <= pwdata[`BIT_MIDI_MODE];
    end else if (write_strobe && reg_index == `IDX_CIR_ROUTE) begin
      cir_on_infrared_transmit <= pwdata[`BIT_CIR_ON_INFRARED_TRANSMIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Primary function drive per port, before the GPIO override
  always_comb begin
    func_drive[0].out = flash_data_out;
    func_drive[0].oe  = {8{flash_data_oe}};
    func_drive[1].out = flash_address_lines[7:0];
    func_drive[1].oe  = 8'hFF;
    func_drive[2].out = flash_address_lines[15:8];
    func_drive[2].oe  = 8'hFF;
    // axes discharge low, buttons only listen
    func_drive[3].out = 8'h00;
    func_drive[3].oe  = {2'b00, joystick_axis_discharge[3:2],
                         2'b00, joystick_axis_discharge[1:0]};
    // flash upper address and strobes, tach inputs idle
    func_drive[4].out = {1'b0, 2'b00, flash_write_enable_n,
                         flash_chip_select_n, flash_read_strobe_n,
                         flash_address_lines[17:16]};
    func_drive[4].oe  = 8'h1F;
    // shared tach pin drives only as address 18
    func_drive[4].out[7] = flash_address_lines[18];
    func_drive[4].oe[7]  = strap_latched;
    // open-drain fan controls and power event
    func_drive[5].out = 8'h00;
    func_drive[5].oe  = {4'h0, ~power_event_output_n,
                         ~fan_control_output};
    func_drive[5].out[4] = (midi_mode & cir_on_infrared_transmit)
                         ? consumer_infrared_transmit : infrared_transmit;
    func_drive[5].oe[4]  = 1'b1;
    func_drive[5].out[6] = midi_mode ? music_serial_output
                                     : consumer_infrared_transmit;
    func_drive[5].oe[6]  = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Function inputs; a pin taken by GPIO shows the idle level instead
  // idle levels on GPIO pins
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      flash_data_lines[b] = gpio_select[0][b] ? `IDLE_FLASH_DATA
                                              : pin_level[0][b];
    end
    for (int j = 0; j < 2; j++) begin
      for (int k = 0; k < 2; k++) begin
        joystick_axis_level[2*j+k] = gpio_select[3][4*j+k]
                                   ? `IDLE_AXIS : pin_level[3][4*j+k];
        joystick_button[2*j+k]     = gpio_select[3][4*j+k+2]
                                   ? `IDLE_BUTTON : pin_level[3][4*j+k+2];
      end
    end
    for (int t = 0; t < 2; t++) begin
      fan_tach_input[t] = gpio_select[4][5+t] ? `IDLE_TACH
                                              : pin_level[4][5+t];
    end
    // tach 3 only when neither GPIO nor address 18
    fan_tach_input[2] = (gpio_select[4][7] || strap_latched)
                      ? `IDLE_TACH : pin_level[4][7];
  end

  // Serial receive paths on pins 83 and 85
  always_comb begin
    // pin 83 feeds infrared receive in every mode unless taken by GPIO
    infrared_receive = gpio_select[5][5] ? `IDLE_SERIAL
                                         : pin_level[5][5];
    // pin 85 feeds CIR or music input by mode
    music_serial_input = (!gpio_select[5][7] && midi_mode)
                       ? pin_level[5][7] : `IDLE_SERIAL;
    if (midi_mode) begin
      // in MIDI mode CIR shares pin 83
      consumer_infrared_receive = gpio_select[5][5] ? `IDLE_SERIAL
                                                    : pin_level[5][5];
    end else begin
      consumer_infrared_receive = gpio_select[5][7] ? `IDLE_SERIAL
                                                    : pin_level[5][7];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_PIN82_GPIO: assert property (
    gpio_select[5][4] |-> (pin_drive[5].out[4] == 1'b0)
      && (pin_drive[5].oe[4] == ~gpio_out[5][4]))
    else $error("pin 82 not open-drain GPIO");

  AST_PIN82_FUNC: assert property (
    !gpio_select[5][4] |-> pin_drive[5].oe[4] && (pin_drive[5].out[4] ==
      ((midi_mode && cir_on_infrared_transmit) ? consumer_infrared_transmit
                                   : infrared_transmit)))
    else $error("pin 82 wrong transmit source");

  AST_PIN83_RX: assert property (
    !gpio_select[5][5] && midi_mode |->
      infrared_receive == pin_level[5][5]
      && consumer_infrared_receive == pin_level[5][5])
    else $error("pin 83 receive not shared");

  AST_PIN84_TX: assert property (
    !gpio_select[5][6] |-> pin_drive[5].out[6] ==
      (midi_mode ? music_serial_output : consumer_infrared_transmit))
    else $error("pin 84 wrong source");

  AST_PIN85_RX: assert property (
    !gpio_select[5][7] && !midi_mode |->
      consumer_infrared_receive == pin_level[5][7]
      && music_serial_input == `IDLE_SERIAL)
    else $error("pin 85 wrong receiver");

  AST_FLASH_DATA: assert property (
    pin_drive[0].oe == ((~gpio_select[0] & {8{flash_data_oe}})
                      | (gpio_select[0] & ~gpio_out[0])))
    else $error("flash data enable wrong");

  AST_FLASH_ADDR: assert property (
    gpio_select[2] == 8'h00 |->
      pin_drive[2].out == flash_address_lines[15:8]
      && pin_drive[2].oe == 8'hFF)
    else $error("flash address high byte wrong");

  AST_FLASH_ADDRESS_LINE_18: assert property (
    strap_latched && !gpio_select[4][7] |-> pin_drive[4].oe[7]
      && pin_drive[4].out[7] == flash_address_lines[18]
      && fan_tach_input[2] == `IDLE_TACH)
    else $error("address 18 not on shared pin");

  AST_STRAP_HOLD: assert property (
    strap_done |=> $stable(strap_latched) [*4])
    else $error("strap changed after capture");

  AST_FAN_OD: assert property (
    !gpio_select[5][0] |-> pin_drive[5].out[0] == 1'b0
      && pin_drive[5].oe[0] == ~fan_control_output[0])
    else $error("fan control not open-drain");

  AST_IDLE_TACH: assert property (
    gpio_select[4][5] |-> fan_tach_input[0] == `IDLE_TACH)
    else $error("tach 1 not idle on GPIO");

  AST_SEL_WRITE: assert property (
    access_cycle && pwrite && !error_flag
      && reg_index == `IDX_SELECT_BASE + 8'h05
      |=> gpio_select[5] == $past(pwdata[7:0]))
    else $error("select 6 write lost");
endmodule

// file: testbench.sv
// Self-checking bench for the multifunction GPIO pin multiplexer.
// Assumes zero-wait APB, 3-flop synced pins and registers at 4 * index.
`timescale 1ns/100ps
`include "pin_mux_consts.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  num_errors++; \
  $display("[FAIL] t=%0t got %h expected %h", $time, got, exp); end end

module testbench;
  import pin_mux_pkg::*;

  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] mode;
    logic [7:0] route;
    logic [2:0] tx;
    logic [7:0] pin;
    logic [3:0] oe;
    logic [3:0] out;
    logic [2:0] rx;
  } row_type;

  // Pins 82 to 85: select, mode, route, {ir,cir,music} tx, port 6 levels
  localparam row_type ROWS [6] = '{
    '{8'h00, 8'h00, 8'h00, 3'b100, 8'h80, 4'h5, 4'h1, 3'b011},
    '{8'h00, 8'h40, 8'h00, 3'b100, 8'h80, 4'h5, 4'h1, 3'b001},
    '{8'h00, 8'h40, 8'h20, 3'b010, 8'h20, 4'h5, 4'h1, 3'b110},
    '{8'h00, 8'h00, 8'h20, 3'b010, 8'h20, 4'h5, 4'h4, 3'b101},
    '{8'hF0, 8'h40, 8'h20, 3'b111, 8'h00, 4'h0, 4'h0, 3'b111},
    '{8'h50, 8'h00, 8'h00, 3'b111, 8'h00, 4'h0, 4'h0, 3'b001}};

  logic                clk = 1'b0;
  logic                rst;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  port_bits_type [5:0] pin_in;
  pin_drive_type [5:0] pin_drive;
  logic                strap;
  logic [18:0]         faddr;
  port_bits_type       fdata_out;
  logic                fdata_oe;
  port_bits_type       flash_data_lines;
  logic                rd_n;
  logic                cs_n;
  logic                we_n;
  logic [3:0]          discharge;
  logic [3:0]          axis_level;
  logic [3:0]          button;
  logic [2:0]          tach;
  logic [2:0]          fan_ctl;
  logic                pme_n;
  logic                ir_tx;
  logic                ir_rx;
  logic                cir_tx;
  logic                cir_rx;
  logic                mus_tx;
  logic                mus_rx;
  logic [31:0]         rd_data;
  logic                rd_err;
  int                  num_errors = 0;
  int                  checks = 0;

  gpio_pin_mux gpio_pin_mux_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_drive(pin_drive),
    .large_flash_strap(strap), .flash_address_lines(faddr),
    .flash_data_out(fdata_out), .flash_data_oe(fdata_oe),
    .flash_data_lines(flash_data_lines), .flash_read_strobe_n(rd_n),
    .flash_chip_select_n(cs_n), .flash_write_enable_n(we_n),
    .joystick_axis_discharge(discharge), .joystick_axis_level(axis_level),
    .joystick_button(button), .fan_tach_input(tach),
    .fan_control_output(fan_ctl), .power_event_output_n(pme_n),
    .infrared_transmit(ir_tx), .infrared_receive(ir_rx),
    .consumer_infrared_transmit(cir_tx), .consumer_infrared_receive(cir_rx),
    .music_serial_output(mus_tx), .music_serial_input(mus_rx));

  // Free-running 50 MHz clock
  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, printed once from here only
  task automatic tally_and_finish;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; waits on pready under a bound, never a fixed count
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [1:0] hi, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {hi, idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    apb(1'b1, idx, 2'b00, {24'h0, val});
  endtask

  // Synced levels land 4 edges after a change; two spare edges of margin
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    row_type r;
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
    pwdata = '0; pin_in = '0; strap = 1'b0; faddr = 19'h2C3A5;
    fdata_out = 8'h3C; fdata_oe = 1'b1; rd_n = 1'b0; cs_n = 1'b1;
    we_n = 1'b0; discharge = 4'b0101; fan_ctl = 3'b010; pme_n = 1'b0;
    ir_tx = 1'b0; cir_tx = 1'b0; mus_tx = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle();
    // Reset values of the selects, outputs and strap status
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, `IDX_SELECT_BASE + 8'(i), 2'b00, 32'h0);
      `CHK(rd_data, {24'h0, 8'(`SELECT_RESET >> (8 * i))})
      apb(1'b0, `IDX_GPIO_OUT_BASE + 8'(i), 2'b00, 32'h0);
      `CHK(rd_data, {24'h0, `GPIO_OUT_RESET})
    end
    apb(1'b0, `IDX_STATUS, 2'b00, 32'h0);
    `CHK(rd_data, 32'h0)
    pin_in[3] <= 8'hC6;
    pin_in[4] <= 8'hE0;
    settle();
    `CHK({axis_level, button}, 8'hFF)
    `CHK(tach, 3'b000)
    // Refused accesses: unmapped, read-only, upper address bits set
    apb(1'b0, 8'h60, 2'b00, 32'h0);
    `CHK({rd_err, rd_data}, {1'b1, 32'h0})
    apb(1'b1, `IDX_PIN_LEVEL_BASE, 2'b00, 32'hFF);
    `CHK(rd_err, 1'b1)
    apb(1'b1, `IDX_SELECT_BASE, 2'b10, 32'hFF);
    `CHK(rd_err, 1'b1)
    apb(1'b0, `IDX_SELECT_BASE, 2'b00, 32'h0);
    `CHK(rd_data, 32'h0)
    // Table of pin 82 to 85 programming cases
    for (int i = 0; i < 6; i++) begin
      r = ROWS[i];
      wr(`IDX_SELECT_BASE + 8'h05, r.sel);
      wr(`IDX_CIR_MODE, r.mode);
      wr(`IDX_CIR_ROUTE, r.route);
      {ir_tx, cir_tx, mus_tx} <= r.tx;
      pin_in[5] <= r.pin;
      settle();
      `CHK(pin_drive[5].oe[7:4], r.oe)
      `CHK(pin_drive[5].out[7:4] & r.oe, r.out)
      `CHK({ir_rx, cir_rx, mus_rx}, r.rx)
    end
    // Flash, joystick, tach and fan functions on ports 1 to 6
    wr(`IDX_SELECT_BASE + 8'h05, 8'h00);
    wr(`IDX_SELECT_BASE + 8'h03, 8'h00);
    wr(`IDX_SELECT_BASE + 8'h04, 8'h00);
    settle();
    `CHK(pin_drive[0], {8'h3C, 8'hFF})
    `CHK(pin_drive[1], {8'hA5, 8'hFF})
    `CHK(pin_drive[2], {8'hC3, 8'hFF})
    `CHK({pin_drive[4].out[4:0], pin_drive[4].oe[4:0]}, 10'h15F)
    `CHK(pin_drive[4].oe[7:5], 3'b000)
    `CHK(tach, 3'b111)
    `CHK({axis_level, button}, 8'h2D)
    `CHK(pin_drive[3].oe, 8'h11)
    `CHK({pin_drive[5].out[3:0], pin_drive[5].oe[3:0]}, 8'h0D)
    fdata_oe <= 1'b0;
    pin_in[0] <= 8'h96;
    settle();
    `CHK({flash_data_lines, pin_drive[0].oe}, 16'h9600)
    // Ports 1 and 2 handed to open-drain GPIO
    wr(`IDX_GPIO_OUT_BASE + 8'h01, 8'h0F);
    wr(`IDX_SELECT_BASE + 8'h01, 8'hFF);
    wr(`IDX_SELECT_BASE, 8'hFF);
    settle();
    `CHK(pin_drive[1], {8'h00, 8'hF0})
    `CHK(flash_data_lines, 8'h00)
    apb(1'b0, `IDX_PIN_LEVEL_BASE, 2'b00, 32'h0);
    `CHK(rd_data, 32'h96)
    // Second reset in mid-run with the large flash strap set
    rst <= 1'b1;
    strap <= 1'b1;
    faddr <= 19'h6C3A5;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle();
    apb(1'b0, `IDX_STATUS, 2'b00, 32'h0);
    `CHK(rd_data, 32'h1)
    wr(`IDX_SELECT_BASE + 8'h04, 8'h00);
    settle();
    `CHK({pin_drive[4].out[7], pin_drive[4].oe[7]}, 2'b11)
    `CHK(tach, 3'b011)
    tally_and_finish();
  end
endmodule
